// ===== rtl/prc_pkg.sv
// Shared constants for the PLL runtime reconfiguration scan link.
// Assumes both ends run on one clock, core_clk, which also serves as the shift clock.
package prc_pkg;
    // ------------------------------------------------------------------
    // Scan chain layout
    // ------------------------------------------------------------------
    localparam int CHAIN_BITS = 144;
    localparam int NUM_CNT    = 7;        // Index 0..4 = C4..C0, 5 = feedback, 6 = prescale.
    localparam int FB_IDX     = 5;
    localparam int PRE_IDX    = 6;
    localparam int CNT_BITS   = 18;
    localparam int CNT_W      = 8;
    localparam int LO_LSB     = 0;
    localparam int HI_LSB     = 8;
    localparam int BYP_BIT    = 16;
    localparam int ODD_BIT    = 17;
    localparam int CP_LSB     = 126;
    localparam int CP_W       = 9;
    localparam int CP_I_W     = 3;
    localparam int LF_LSB     = 135;
    localparam int LF_W       = 9;
    localparam int LFR_LSB    = 0;
    localparam int LFR_W      = 5;
    localparam int LFC_LSB    = 5;
    localparam int LFC_W      = 2;
    localparam int TAP_W      = 3;        // Eight VCO phases.
    localparam int SEL_W      = 3;
    localparam int COARSE_W   = 8;
    localparam logic [COARSE_W-1:0] COARSE_ZERO_DEG = 8'h01;
    localparam int BITCNT_W   = 8;
    localparam logic [BITCNT_W-1:0] LAST_BIT = 8'h8F;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int SCAN_MAX_MHZ     = 100;
    localparam int CORE_MHZ         = 40;
    localparam int CORE_PERIOD_NS   = 25;
    localparam int LOOP_RESET_NS    = 10;
    localparam int LOOP_RESET_CYC_I = (LOOP_RESET_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam logic [3:0] LOOP_RESET_CYC =
        4'((LOOP_RESET_CYC_I < 1) ? 1 : LOOP_RESET_CYC_I);

    // ------------------------------------------------------------------
    // Controller registers
    // ------------------------------------------------------------------
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    localparam int DATA_WORDS = 5;
    localparam logic [ADDR_W-1:0] REG_DATA0 = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CTRL  = 8'h14;
    localparam logic [ADDR_W-1:0] REG_STAT  = 8'h18;
    localparam int CTRL_START   = 0;
    localparam int CTRL_AUTORST = 1;
    localparam int STAT_BUSY    = 0;
    localparam int STAT_FIN     = 1;
    localparam int STAT_DONE    = 2;
    localparam int STAT_CNT_LSB = 8;
endpackage

// ===== rtl/prc_scan_if.sv
// Scan link between the reconfiguring user logic and the PLL.
// Assumes both ends sample every signal except loop_reset on the rising edge of core_clk; the PLL end takes loop_reset asynchronously.
`timescale 1ns/100ps
`default_nettype none
interface prc_scan_if;
    logic scan_ena;
    logic scan_data;
    logic cfg_apply;
    logic scan_done;
    logic loop_reset;

    modport dev (input scan_ena, input scan_data, input cfg_apply, input loop_reset,
                 output scan_done);
    modport ctl (output scan_ena, output scan_data, output cfg_apply, output loop_reset,
                 input scan_done);
endinterface
`default_nettype wire

// ===== rtl/prc_pll_device.sv
// PLL end of the runtime reconfiguration link: scan chain, counters, phase taps.
// Assumes core_clk stands for both the shift clock and the VCO; loop_reset is asynchronous.
//
// Overview of operation
// [RULE1] Shift clock stays at or below 100 MHz.
// [RULE2] Settings enter serially through a shift chain.
// [RULE3] Apply pulse copies chain into active settings.
// [RULE4] Each counter switches on its own period boundary.
// [RULE5] Gate rises one cycle before first bit.
// [RULE6] Capture starts second edge after gate rises.
// [RULE7] Gate drops after exactly 144 bits.
// [RULE8] Done flag high until all counters updated.
// [RULE9] Loop reset follows any divider or filter change.
// [RULE10] Whole sequence repeats without limit.
// [RULE11] All dividers, pump and filter are reprogrammable.
// [RULE12] Chain never alters phase offsets.
// [RULE13] Post-scale and feedback counters pick one of eight taps.
// [RULE14] Coarse offset holds off counter start.
// [RULE15] Coarse delay is value minus one periods.
// [RULE16] Phase step moves tap only, one cycle.
// [RULE17] Upstream loop low, downstream high bandwidth.
// [RULE18] First bit C4 low LSB, last filter MSB.
// [RULE19] Counters have 8-bit high and low counts.
// [RULE20] Bypass bit makes counter divide by one.
// [RULE21] Odd bit moves half cycle to low time.
// [RULE22] No new scan before done flag falls.
`timescale 1ns/100ps
`default_nettype none
module prc_pll_device #(
    parameter logic [prc_pkg::CHAIN_BITS-1:0] RESET_CFG = '0,
    parameter logic [prc_pkg::NUM_CNT*prc_pkg::COARSE_W-1:0] START_DLY =
        {prc_pkg::NUM_CNT{prc_pkg::COARSE_ZERO_DEG}}
) (
    input  wire logic                                      core_clk,
    input  wire logic                                      reset_n,
    prc_scan_if.dev                                        scan,
    input  wire logic                                      phase_step,
    input  wire logic                                      phase_up,
    input  wire logic [prc_pkg::SEL_W-1:0]                 phase_sel,
    output logic      [prc_pkg::NUM_CNT-1:0]               clk_out,
    output logic      [prc_pkg::NUM_CNT-1:0]               odd_fall,
    output logic      [prc_pkg::NUM_CNT*prc_pkg::TAP_W-1:0] phase_tap,
    output logic      [prc_pkg::CP_I_W-1:0]                charge_pump_current,
    output logic      [prc_pkg::LFR_W-1:0]                 loop_filter_resistor_field,
    output logic      [prc_pkg::LFC_W-1:0]                 loop_filter_capacitor_field
);
    import prc_pkg::*;

    // ------------------------------------------------------------------
    // Scan chain and apply
    // ------------------------------------------------------------------
    logic [CHAIN_BITS-1:0] chain_r;
    logic [CHAIN_BITS-1:0] staged_r;
    logic                  gate_d_r;
    logic                  done_r;
    logic [CP_W-1:0]       cp_r;
    logic [LF_W-1:0]       lf_r;
    logic [NUM_CNT-1:0]    pend;

    // The chain only moves once the gate has been seen high for a full cycle,
    // so the first shift lands on the second rising edge after the gate rises.
    wire shift_en  = scan.scan_ena & gate_d_r;
    // Counter logic restarts from either the core reset or the loop reset.
    wire loop_rst_n = reset_n & ~scan.loop_reset;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gate_d_r <= 1'b0;
            chain_r  <= '0;
        end else begin
            gate_d_r <= scan.scan_ena; // [RULE6]
            if (shift_en) begin
                // New bits enter at the top, so the first bit ends in bit 0.
                chain_r <= {scan.scan_data, chain_r[CHAIN_BITS-1:1]}; // [RULE2] [RULE18]
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            staged_r <= RESET_CFG;
            cp_r     <= RESET_CFG[CP_LSB +: CP_W];
            lf_r     <= RESET_CFG[LF_LSB +: LF_W];
            done_r   <= 1'b0;
        end else begin
            if (scan.cfg_apply) begin
                staged_r <= chain_r; // [RULE3] [RULE10]
                // Pump and filter have no counter clock and switch at once.
                cp_r     <= chain_r[CP_LSB +: CP_W]; // [RULE11]
                lf_r     <= chain_r[LF_LSB +: LF_W];
            end
            done_r <= scan.cfg_apply | (|pend); // [RULE8]
        end
    end

    assign scan.scan_done               = done_r;
    assign charge_pump_current          = cp_r[CP_I_W-1:0];
    assign loop_filter_resistor_field   = lf_r[LFR_LSB +: LFR_W];
    assign loop_filter_capacitor_field  = lf_r[LFC_LSB +: LFC_W];

    // ------------------------------------------------------------------
    // Divider counters
    // ------------------------------------------------------------------
    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
        localparam logic [COARSE_W-1:0] START_C = START_DLY[i*COARSE_W +: COARSE_W];
        localparam logic [COARSE_W-1:0] DLY0 =
            (START_C == '0) ? '0 : START_C - COARSE_ZERO_DEG;
        localparam logic [SEL_W-1:0] SEL_ME = SEL_W'(i);

        logic [CNT_BITS-1:0] act_r;
        logic                pend_r;
        logic                run_r;
        logic                low_r;
        logic                clk_r;
        logic                odd_r;
        logic [COARSE_W-1:0] dly_r;
        logic [CNT_W-1:0]    cnt_r;
        logic [TAP_W-1:0]    tap_r;

        wire [CNT_W-1:0] hi_cnt = act_r[HI_LSB +: CNT_W];
        wire [CNT_W-1:0] lo_cnt = act_r[LO_LSB +: CNT_W];
        // A zero count is taken as one so that no phase can stall the counter.
        wire [CNT_W-1:0] hi_len = (hi_cnt == '0) ? 8'h01 : hi_cnt; // [RULE19]
        wire [CNT_W-1:0] lo_len = (lo_cnt == '0) ? 8'h01 : lo_cnt;
        wire             byp    = act_r[BYP_BIT];
        wire             odd    = act_r[ODD_BIT];
        wire             hi_end = ~low_r & (cnt_r == hi_len);
        wire             lo_end = low_r & (cnt_r == lo_len);
        wire             wrap   = run_r & (byp | lo_end);
        // A new setting is taken only at this counter's own period boundary,
        // or at once while the counter has not started yet.
        wire             take   = pend_r & (wrap | ~run_r); // [RULE4]
        wire             step   = phase_step & (phase_sel == SEL_ME) & (i != PRE_IDX);

        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                pend_r <= 1'b0;
                act_r  <= RESET_CFG[i*CNT_BITS +: CNT_BITS];
            end else if (scan.cfg_apply) begin
                pend_r <= 1'b1; // [RULE8]
            end else if (take) begin
                pend_r <= 1'b0;
                act_r  <= staged_r[i*CNT_BITS +: CNT_BITS]; // [RULE4] [RULE11]
            end
        end

        always_ff @(posedge core_clk or negedge loop_rst_n) begin
            if (!loop_rst_n) begin
                run_r <= 1'b0;
                low_r <= 1'b0;
                clk_r <= 1'b0;
                odd_r <= 1'b0;
                dly_r <= DLY0; // [RULE15]
                cnt_r <= 8'h01;
            end else begin
                clk_r <= run_r & (byp | (low_r ? lo_end : ~hi_end)); // [RULE19] [RULE20]
                // Marks a fall that the VCO falling edge would carry.
                odd_r <= run_r & ~byp & odd & hi_end; // [RULE21]
                if (!run_r) begin
                    if (dly_r == '0) begin
                        run_r <= 1'b1;
                    end else begin
                        dly_r <= dly_r - 8'h01; // [RULE14]
                    end
                end else if (byp || hi_end || lo_end) begin
                    low_r <= ~byp & hi_end; // [RULE20]
                    cnt_r <= 8'h01;
                end else begin
                    cnt_r <= cnt_r + 8'h01;
                end
            end
        end

        // The tap is untouched by the chain, so an offset survives only here.
        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                tap_r <= '0;
            end else if (step) begin
                tap_r <= phase_up ? tap_r + 3'h1 : tap_r - 3'h1; // [RULE13] [RULE16] [RULE12]
            end
        end

        assign pend[i]                      = pend_r;
        assign clk_out[i]                   = clk_r;
        assign odd_fall[i]                  = odd_r;
        assign phase_tap[i*TAP_W +: TAP_W]  = tap_r;
    end
endmodule
`default_nettype wire

// ===== rtl/prc_scan_ctl.sv
// User-logic end: sequences gate, 144-bit shift, apply, done wait and loop reset.
// Assumes core_clk is the shift clock and software drives the plain register port.
`timescale 1ns/100ps
`default_nettype none
module prc_scan_ctl (
    input  wire logic                         core_clk,
    input  wire logic                         reset_n,
    prc_scan_if.ctl                           scan,
    input  wire logic [prc_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [prc_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [prc_pkg::DATA_W-1:0]   reg_rdata
);
    import prc_pkg::*;

    localparam int CFG_W = DATA_WORDS * DATA_W;
    localparam logic [CFG_W-1:0] CFG_KEEP = {{(CFG_W-CHAIN_BITS){1'b0}}, {CHAIN_BITS{1'b1}}};

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_GATE   = 7'h02,
        ST_SHIFT  = 7'h04,
        ST_UNGATE = 7'h08,
        ST_APPLY  = 7'h10,
        ST_WAIT   = 7'h20,
        ST_LRST   = 7'h40
    } prc_state_t;

    prc_state_t            state_r;
    logic [CFG_W-1:0]      cfg_r;
    logic [CHAIN_BITS-1:0] sh_r;
    logic [BITCNT_W-1:0]   bit_r;
    logic [3:0]            rst_cnt_r;
    logic                  ena_r;
    logic                  data_r;
    logic                  apply_r;
    logic                  lrst_r;
    logic                  autorst_r;
    logic                  fin_r;
    logic [DATA_W-1:0]     rdata_r;
    logic [DATA_W-1:0]     rd_val;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    wire [5:0] widx     = reg_addr[7:2];
    wire       hit_data = (reg_addr[1:0] == 2'h0) && (widx < 6'(DATA_WORDS));
    wire       hit_ctrl = (reg_addr == REG_CTRL);
    wire       hit_stat = (reg_addr == REG_STAT);
    wire       busy     = (state_r != ST_IDLE);
    wire       start    = reg_wr & hit_ctrl & reg_wdata[CTRL_START] & ~busy;
    wire       finish   = (state_r == ST_WAIT) & ~scan.scan_done & ~autorst_r
                        | (state_r == ST_LRST) & (rst_cnt_r == 4'h1);

    always_comb begin
        rd_val = '0;
        if (hit_data) begin
            rd_val = cfg_r[widx*DATA_W +: DATA_W];
        end else if (hit_ctrl) begin
            rd_val[CTRL_AUTORST] = autorst_r;
        end else if (hit_stat) begin
            rd_val[STAT_BUSY] = busy;
            rd_val[STAT_FIN]  = fin_r;
            rd_val[STAT_DONE] = scan.scan_done;
            rd_val[STAT_CNT_LSB +: BITCNT_W] = bit_r;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_r     <= '0;
            autorst_r <= 1'b0;
            fin_r     <= 1'b0;
            rdata_r   <= '0;
        end else begin
            rdata_r <= reg_rd ? rd_val : '0;
            // Configuration words are frozen while a sequence runs.
            if (reg_wr && hit_data && !busy) begin
                cfg_r[widx*DATA_W +: DATA_W] <= reg_wdata & CFG_KEEP[widx*DATA_W +: DATA_W];
            end
            if (reg_wr && hit_ctrl) begin
                autorst_r <= reg_wdata[CTRL_AUTORST];
            end
            // Completion wins over a clear in the same cycle.
            if (finish) begin
                fin_r <= 1'b1;
            end else if (reg_wr && hit_stat && reg_wdata[STAT_FIN]) begin
                fin_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r   <= ST_IDLE;
            sh_r      <= '0;
            bit_r     <= '0;
            rst_cnt_r <= '0;
            ena_r     <= 1'b0;
            data_r    <= 1'b0;
            apply_r   <= 1'b0;
            lrst_r    <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        sh_r    <= cfg_r[CHAIN_BITS-1:0];
                        bit_r   <= '0;
                        ena_r   <= 1'b1; // [RULE5]
                        state_r <= ST_GATE;
                    end
                end
                ST_GATE: begin
                    // The shift clock is core_clk itself, 40 MHz, under the limit.
                    data_r  <= sh_r[0]; // [RULE1] [RULE18]
                    sh_r    <= sh_r >> 1;
                    state_r <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    data_r <= sh_r[0]; // [RULE2]
                    sh_r   <= sh_r >> 1;
                    bit_r  <= bit_r + 8'h01;
                    if (bit_r == LAST_BIT) begin
                        ena_r   <= 1'b0; // [RULE7]
                        state_r <= ST_UNGATE;
                    end
                end
                ST_UNGATE: begin
                    apply_r <= 1'b1; // [RULE3]
                    state_r <= ST_APPLY;
                end
                ST_APPLY: begin
                    apply_r <= 1'b0;
                    state_r <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (!scan.scan_done) begin // [RULE22] [RULE8]
                        if (autorst_r) begin
                            lrst_r    <= 1'b1; // [RULE9]
                            rst_cnt_r <= LOOP_RESET_CYC;
                            state_r   <= ST_LRST;
                        end else begin
                            state_r <= ST_IDLE; // [RULE10]
                        end
                    end
                end
                ST_LRST: begin
                    rst_cnt_r <= rst_cnt_r - 4'h1;
                    if (rst_cnt_r == 4'h1) begin
                        lrst_r  <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    assign scan.scan_ena  = ena_r;
    assign scan.scan_data = data_r;
    assign scan.cfg_apply = apply_r;
    assign scan.loop_reset = lrst_r;
    assign reg_rdata      = rdata_r;
endmodule
`default_nettype wire

// ===== dv/prc_scan_checker.sv
// Concurrent checks on the scan link between the two ends.
// Assumes the bench wires the interface signals, core_clk and reset_n to its inputs.
`timescale 1ns/100ps
`default_nettype none
module prc_scan_checker (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic scan_ena,
    input  wire logic scan_data,
    input  wire logic cfg_apply,
    input  wire logic scan_done,
    input  wire logic loop_reset
);
    // ------------------------------------------------------------------
    // Gate length counter
    // ------------------------------------------------------------------
    logic [8:0] gate_len_r;
    logic [8:0] gate_len_nxt;

    assign gate_len_nxt = scan_ena ? gate_len_r + 9'h001 : 9'h000;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gate_len_r <= 9'h000;
        end else begin
            gate_len_r <= gate_len_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // One gate cycle plus exactly 144 shifting cycles.
    a_gate_length: assert property ($fell(scan_ena) |-> gate_len_r == 9'h091)
        else $error("gate length wrong");
    a_apply_ungated: assert property (cfg_apply |-> !scan_ena)
        else $error("apply while gate open");
    a_ungate_apply: assert property ($fell(scan_ena) |=> cfg_apply)
        else $error("apply missing after ungate");
    a_apply_pulse: assert property (cfg_apply |=> !cfg_apply)
        else $error("apply longer than one cycle");
    a_done_rises: assert property (cfg_apply |=> scan_done)
        else $error("done flag did not rise");
    a_done_bounded: assert property ($rose(scan_done) |-> ##[1:1000] !scan_done)
        else $error("done flag never fell");
    a_busy_quiet: assert property (scan_done |-> !scan_ena && !cfg_apply)
        else $error("new sequence during reconfiguration");
    a_reset_pulse: assert property (loop_reset |-> !scan_done ##1 !loop_reset)
        else $error("loop reset misplaced");

    c_apply: cover property (cfg_apply);
    c_done_fall: cover property ($fell(scan_done));
    c_loop_reset: cover property (loop_reset);
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Bench joining the controller and the PLL end through the scan interface.
// Assumes the register map and chain layout of prc_pkg; one clock at 40 MHz.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import prc_pkg::*;
    logic                        core_clk;
    logic                        reset_n;
    logic                        reg_wr;
    logic                        reg_rd;
    logic                        phase_step;
    logic                        phase_up;
    logic [ADDR_W-1:0]           reg_addr;
    logic [DATA_W-1:0]           reg_wdata;
    logic [DATA_W-1:0]           reg_rdata;
    logic [SEL_W-1:0]            phase_sel;
    logic [NUM_CNT-1:0]          clk_out;
    logic [NUM_CNT-1:0]          odd_fall;
    logic [NUM_CNT*TAP_W-1:0]    phase_tap;
    logic [CP_I_W-1:0]           pump;
    logic [LFR_W-1:0]            lf_res;
    logic [LFC_W-1:0]            lf_cap;
    logic [CHAIN_BITS-1:0]       cap_r;
    logic [CHAIN_BITS-1:0]       pat;
    logic                        ena_d;
    int                          miscompares;
    int                          checks_done;
    int                          shift_cnt;
    int                          rst_cnt;

    prc_scan_if scan_bus ();
    prc_scan_ctl i_prc_scan_ctl (.core_clk(core_clk), .reset_n(reset_n), .scan(scan_bus.ctl),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    prc_pll_device i_prc_pll_device (.core_clk(core_clk), .reset_n(reset_n),
        .scan(scan_bus.dev), .phase_step(phase_step), .phase_up(phase_up),
        .phase_sel(phase_sel), .clk_out(clk_out), .odd_fall(odd_fall), .phase_tap(phase_tap),
        .charge_pump_current(pump), .loop_filter_resistor_field(lf_res),
        .loop_filter_capacitor_field(lf_cap));
    prc_scan_checker i_prc_scan_checker (.core_clk(core_clk), .reset_n(reset_n),
        .scan_ena(scan_bus.scan_ena), .scan_data(scan_bus.scan_data),
        .cfg_apply(scan_bus.cfg_apply), .scan_done(scan_bus.scan_done),
        .loop_reset(scan_bus.loop_reset));

    // ------------------------------------------------------------------
    // Wire monitor: records what the device really shifts in.
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        ena_d <= scan_bus.scan_ena;
        if (scan_bus.scan_ena && ena_d) begin
            cap_r <= {scan_bus.scan_data, cap_r[CHAIN_BITS-1:1]};
            shift_cnt <= shift_cnt + 1;
        end
        if (scan_bus.loop_reset) begin
            rst_cnt <= rst_cnt + 1;
        end
    end

    // ------------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------------
    task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check144(input string what, input logic [143:0] exp, input logic [143:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask

    task automatic step_tap(input logic [SEL_W-1:0] sel, input logic up);
        @(posedge core_clk);
        phase_step <= 1'b1;
        phase_sel <= sel;
        phase_up <= up;
        @(posedge core_clk);
        phase_step <= 1'b0;
        @(negedge core_clk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset_map();
        logic [DATA_W-1:0] d;
        reg_read(REG_STAT, d);
        check32("stat_after_reset", 32'h0000_0000, d);
        reg_read(8'h40, d);
        check32("unmapped_read", 32'h0000_0000, d);
        $display("test reset_map done");
    endtask

    // Full gate, shift, apply, wait cycle; the chain seen on the wire must equal p.
    task automatic run_cfg(input logic [CHAIN_BITS-1:0] p, input logic autorst);
        logic [DATA_W-1:0] d;
        int n;
        @(negedge core_clk);
        shift_cnt = 0;
        rst_cnt = 0;
        for (int w = 0; w < DATA_WORDS - 1; w++) begin
            reg_write(REG_DATA0 + 8'(4 * w), p[32*w +: 32]);
        end
        reg_write(REG_DATA0 + 8'h10, {16'h0000, p[143:128]});
        reg_write(REG_CTRL, {30'h0, autorst, 1'b1});
        d = 32'h0;
        n = 0;
        while (d[STAT_FIN] !== 1'b1 && n < 2000) begin
            reg_read(REG_STAT, d);
            n++;
        end
        check32("status", 32'h0000_9002, d & 32'h0000_FF07);
        check144("chain", p, cap_r);
        check32("shift_count", 32'd144, 32'(shift_cnt));
        check32("loop_reset_count", {31'h0, autorst}, 32'(rst_cnt));
        check32("pump", {29'h0, p[128:126]}, {29'h0, pump});
        check32("resistor", {27'h0, p[139:135]}, {27'h0, lf_res});
        check32("capacitor", {30'h0, p[141:140]}, {30'h0, lf_cap});
        if (p[BYP_BIT]) begin
            repeat (3) begin
                @(negedge core_clk);
                check32("bypass_out", 32'h1, {31'h0, clk_out[0]});
            end
        end
        for (n = 0; n < 600 && p[ODD_BIT] && !odd_fall[0]; n++) begin
            @(negedge core_clk);
        end
        check32("odd", {31'h0, p[ODD_BIT] & ~p[BYP_BIT]}, {31'h0, odd_fall[0]});
        reg_write(REG_STAT, 32'h0000_0002);
        $display("test reconfigure done");
    endtask

    // Fine steps wrap over eight taps and survive a later reconfiguration.
    task automatic test_phase();
        step_tap(3'h0, 1'b1);
        check32("tap_c4_up", 32'h1, {29'h0, phase_tap[2:0]});
        step_tap(3'h0, 1'b0);
        step_tap(3'h0, 1'b0);
        check32("tap_c4_wrap", 32'h7, {29'h0, phase_tap[2:0]});
        step_tap(3'h5, 1'b1);
        check32("tap_fb_up", 32'h1, {29'h0, phase_tap[17:15]});
        $display("test phase done");
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        #(25 * 80000);
        miscompares++;
        final_report();
    end

    initial begin
        {reg_wr, reg_rd, phase_step, phase_up, ena_d} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        phase_sel = '0;
        cap_r = '0;
        {miscompares, checks_done, shift_cnt, rst_cnt} = '0;
        reset_n = 1'b0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        test_reset_map();
        pat = '0;
        pat[15:0] = 16'hA5C3;
        pat[BYP_BIT] = 1'b1;
        pat[77:60] = 18'h25A5A;
        pat[128:126] = 3'h5;
        pat[139:135] = 5'h13;
        pat[141:140] = 2'h3;
        pat[143] = 1'b1;
        run_cfg(pat, 1'b1);
        test_phase();
        run_cfg(~pat, 1'b0);
        check32("tap_kept", 32'h7, {29'h0, phase_tap[2:0]});
        final_report();
    end
endmodule
`default_nettype wire
